/* rtl/fscw_pkg.sv */
package fscw_pkg;

	// Command opcodes
	localparam logic [7:0] OP_WRITE_LOCK_BYTE   = 8'h01;
	localparam logic [7:0] OP_WRITE_ENABLE_BYTE = 8'h31;
	localparam logic [7:0] OP_READ_CONFIG       = 8'h3F;

	// Field positions, first status-byte write
	localparam int LOCK_BIT    = 7;
	localparam int GLOBAL_MSB  = 5;
	localparam int GLOBAL_LSB  = 2;

	// Field positions, second status-byte write
	localparam int RESET_EN_BIT    = 4;
	localparam int LOCKDOWN_EN_BIT = 3;

	// Configuration byte layout
	localparam int         QUAD_EN_BIT     = 7;
	localparam logic [6:0] CONFIG_RESERVED = 7'h00;

	// Bit counting within a byte
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST  = 3'h7;

	// Reset values of volatile status bits
	localparam logic LOCK_RST        = 1'h0;
	localparam logic LATCH_RST       = 1'h0;
	localparam logic RESET_EN_RST    = 1'h0;
	localparam logic LOCKDOWN_EN_RST = 1'h0;
	localparam logic FROZEN_RST      = 1'h0;

	// Frame phase on the serial link
	typedef enum logic [2:0] {
		PH_OPCODE,
		PH_DATA,
		PH_EXTRA,
		PH_READ,
		PH_IGNORE
	} fscw_phase_t;

	typedef struct packed {
		fscw_phase_t phase;
		logic [2:0]  bitpos;
		logic [6:0]  shift;
		logic [7:0]  opcode;
		logic [7:0]  data;
		logic        frame_tog;
		logic [1:0]  busy_sync;
		logic [1:0]  quad_sync;
	} fscw_link_t;

	typedef struct packed {
		logic [2:0] cs_sync;
		logic [1:0] tog_sync;
		logic       tog_seen;
		logic [1:0] wp_sync;
		logic [1:0] nvq_sync;
		logic       busy;
		logic       protection_lock;
		logic       write_latch;
		logic       soft_reset_enable;
		logic       lockdown_enable;
		logic       lockdown_frozen;
		logic       global_req;
		logic [3:0] global_field;
	} fscw_sys_t;

endpackage

/* rtl/fscw_status_config.sv */
`timescale 1ns/1ps

// Frame start flag: set while chip select is high, cleared by the first clock of a frame
module fscw_frame_start (
	input  wire logic i_sck,
	input  wire logic i_cs_n,
	output logic      o_start
);
	logic start_q;

	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			start_q <= 1'b1;
		end else begin
			start_q <= 1'b0;
		end
	end

	assign o_start = start_q;
endmodule

module fscw_status_config (
	input  wire logic       i_clock,
	input  wire logic       i_resetn,
	input  wire logic       i_sck,
	input  wire logic       i_cs_n,
	input  wire logic       i_si,
	input  wire logic       i_wp_n,
	input  wire logic       i_nv_quad_enable,
	input  wire logic       i_busy,
	input  wire logic       i_write_enable,
	input  wire logic       i_freeze_lockdown,
	output logic            o_so,
	output logic            o_so_oe,
	output logic            o_protection_lock,
	output logic            o_write_latch,
	output logic            o_soft_reset_enable,
	output logic            o_lockdown_enable,
	output logic            o_quad_enable,
	output logic            o_wp_pause_disable,
	output logic            o_ready_busy_flag,
	output logic            o_global_req,
	output logic [3:0]      o_global_field
);

	fscw_pkg::fscw_link_t link_q;
	fscw_pkg::fscw_link_t link_d;
	fscw_pkg::fscw_sys_t  sys_q;
	fscw_pkg::fscw_sys_t  sys_d;
	logic                 start;
	logic [7:0]           config_byte;

	fscw_frame_start u_frame_start (
		.i_sck   (i_sck),
		.i_cs_n  (i_cs_n),
		.o_start (start)
	);

	// Reserved bits read as zero; quad enable comes from the nonvolatile cell
	assign config_byte = {link_q.quad_sync[1], fscw_pkg::CONFIG_RESERVED};

	// ---------------- Link domain, clocked by the serial clock ----------------
	always_comb begin
		logic [7:0]            byte_in;
		logic [6:0]            shift_base;
		logic [2:0]            bitpos;
		fscw_pkg::fscw_phase_t phase;
		byte_in    = 8'h00;
		shift_base = start ? 7'h00 : link_q.shift;
		bitpos     = start ? fscw_pkg::BIT_FIRST : link_q.bitpos;
		phase      = start ? fscw_pkg::PH_OPCODE : link_q.phase;
		link_d     = link_q;

		// Busy and quad enable cross from the system clock; both are levels
		link_d.busy_sync = {link_q.busy_sync[0], sys_q.busy};
		link_d.quad_sync = {link_q.quad_sync[0], sys_q.nvq_sync[1]};

		// Link flops have no reset, so the frame marker is taken from the
		// acknowledged value; that value only moves while chip select is high
		if (start) begin
			link_d.frame_tog = ~sys_q.tog_seen;
		end

		byte_in      = {shift_base, i_si};
		link_d.shift = byte_in[6:0];
		link_d.bitpos = bitpos + 3'h1;
		link_d.phase  = phase;

		if (bitpos == fscw_pkg::BIT_LAST) begin
			unique case (phase)
				fscw_pkg::PH_OPCODE: begin
					link_d.opcode = byte_in;
					if (byte_in == fscw_pkg::OP_READ_CONFIG) begin
						// Refused while an internal operation runs
						link_d.phase = link_q.busy_sync[1] ? fscw_pkg::PH_IGNORE
							: fscw_pkg::PH_READ;
					end else if (byte_in == fscw_pkg::OP_WRITE_LOCK_BYTE
						|| byte_in == fscw_pkg::OP_WRITE_ENABLE_BYTE) begin
						link_d.phase = fscw_pkg::PH_DATA;
					end else begin
						link_d.phase = fscw_pkg::PH_IGNORE;
					end
				end
				fscw_pkg::PH_DATA: begin
					link_d.data  = byte_in;
					link_d.phase = fscw_pkg::PH_EXTRA;
				end
				fscw_pkg::PH_EXTRA: begin
					link_d.phase = fscw_pkg::PH_EXTRA;
				end
				fscw_pkg::PH_READ: begin
					link_d.phase = fscw_pkg::PH_READ;
				end
				fscw_pkg::PH_IGNORE: begin
					link_d.phase = fscw_pkg::PH_IGNORE;
				end
			endcase
		end
	end

	// No reset here: each frame restarts from the start flag
	always_ff @(posedge i_sck) begin
		link_q <= link_d;
	end

	// Bit index wraps, so the byte repeats while clocks run
	assign o_so    = (link_q.phase == fscw_pkg::PH_READ) ? config_byte[~link_q.bitpos]
		: 1'b0;
	// Start flag rises with chip select, so the driver lets go at once
	assign o_so_oe = (link_q.phase == fscw_pkg::PH_READ) && !start;

	// ---------------- System domain ----------------
	always_comb begin
		logic commit;
		logic recognized;
		logic complete;
		logic wp_active;
		logic new_lock;
		commit     = 1'b0;
		recognized = 1'b0;
		complete   = 1'b0;
		wp_active  = 1'b0;
		new_lock   = 1'b0;
		sys_d      = sys_q;

		sys_d.cs_sync  = {sys_q.cs_sync[1:0], i_cs_n};
		sys_d.tog_sync = {sys_q.tog_sync[0], link_q.frame_tog};
		sys_d.wp_sync  = {sys_q.wp_sync[0], i_wp_n};
		sys_d.nvq_sync = {sys_q.nvq_sync[0], i_nv_quad_enable};
		sys_d.busy     = i_busy;
		sys_d.global_req = 1'b0;

		// Link state is frozen once chip select is high and the clock idles
		commit = sys_q.cs_sync[1] && !sys_q.cs_sync[2]
			&& (sys_q.tog_sync[1] != sys_q.tog_seen);
		if (commit) begin
			sys_d.tog_seen = sys_q.tog_sync[1];
		end

		// Full opcode needed before the latch is touched
		recognized = (link_q.phase == fscw_pkg::PH_DATA)
			|| (link_q.phase == fscw_pkg::PH_EXTRA);
		complete   = (link_q.phase == fscw_pkg::PH_EXTRA)
			&& (link_q.bitpos == fscw_pkg::BIT_FIRST);
		// Quad mode turns the protect pin into data
		wp_active  = !sys_q.wp_sync[1] && !sys_q.nvq_sync[1];
		new_lock   = link_q.data[fscw_pkg::LOCK_BIT];

		if (commit && recognized) begin
			sys_d.write_latch = 1'b0;
			if (sys_q.write_latch && complete) begin
				if (link_q.opcode == fscw_pkg::OP_WRITE_LOCK_BYTE) begin
					if (!(wp_active && !new_lock && sys_q.protection_lock)) begin
						sys_d.protection_lock = new_lock;
						// Prior lock decides; a locked device ignores global ops
						if (!sys_q.protection_lock) begin
							sys_d.global_req   = 1'b1;
							sys_d.global_field = link_q.data[fscw_pkg::GLOBAL_MSB:
								fscw_pkg::GLOBAL_LSB];
						end
					end
				end else begin
					sys_d.soft_reset_enable = link_q.data[fscw_pkg::RESET_EN_BIT];
					if (!sys_q.lockdown_frozen) begin
						sys_d.lockdown_enable = link_q.data[fscw_pkg::LOCKDOWN_EN_BIT];
					end
				end
			end
		end

		// Latch set wins over a clear in the same cycle; a freeze clears lockdown enable over a write
		if (i_write_enable) begin
			sys_d.write_latch = 1'b1;
		end
		if (i_freeze_lockdown) begin
			sys_d.lockdown_frozen = 1'b1;
			sys_d.lockdown_enable = 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			sys_q                   <= '0;
			sys_q.cs_sync           <= 3'h7;
			sys_q.wp_sync           <= 2'h3;
			sys_q.protection_lock   <= fscw_pkg::LOCK_RST;
			sys_q.write_latch       <= fscw_pkg::LATCH_RST;
			sys_q.soft_reset_enable <= fscw_pkg::RESET_EN_RST;
			sys_q.lockdown_enable   <= fscw_pkg::LOCKDOWN_EN_RST;
			sys_q.lockdown_frozen   <= fscw_pkg::FROZEN_RST;
		end else begin
			sys_q <= sys_d;
		end
	end

	assign o_protection_lock   = sys_q.protection_lock;
	assign o_write_latch       = sys_q.write_latch;
	assign o_soft_reset_enable = sys_q.soft_reset_enable;
	assign o_lockdown_enable   = sys_q.lockdown_enable;
	assign o_quad_enable       = sys_q.nvq_sync[1];
	assign o_wp_pause_disable  = sys_q.nvq_sync[1];
	assign o_ready_busy_flag   = sys_q.busy;
	assign o_global_req        = sys_q.global_req;
	assign o_global_field      = sys_q.global_field;

endmodule

/* testbench/fscw_host_model.sv */
`timescale 1ns/1ps
module fscw_host_model (
	output logic      o_sck,
	output logic      o_cs_n,
	output logic      o_si,
	input  wire logic i_so,
	input  wire logic i_so_oe
);
	logic [15:0] rd_q;
	initial begin
		o_sck = 1'h0;
		o_cs_n = 1'h1;
		o_si = 1'h0;
		rd_q = 16'h0000;
	end
	// Clock stands still outside frames; a released data line flips
	task automatic frame(input logic [31:0] w, input int n);
		o_cs_n = 1'h0;
		#5;
		for (int i = 0; i < n; i++) begin
			o_si = w[31-i];
			#7.5;
			if (i >= 8) rd_q = {rd_q[14:0], i_so & i_so_oe};
			o_sck = 1'h1;
			#7.5;
			o_sck = 1'h0;
		end
		#5;
		o_cs_n = 1'h1;
		o_si = ~o_si;
		#60;
	endtask
endmodule

/* testbench/fscw_sc_chk.sv */
`timescale 1ns/1ps
module fscw_sc_chk (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_cs_n,
	input wire logic i_wp_n,
	input wire logic i_nv_quad_enable,
	input wire logic i_busy,
	input wire logic i_write_enable,
	input wire logic i_freeze_lockdown,
	input wire logic o_so_oe,
	input wire logic o_protection_lock,
	input wire logic o_write_latch,
	input wire logic o_soft_reset_enable,
	input wire logic o_lockdown_enable,
	input wire logic o_quad_enable,
	input wire logic o_wp_pause_disable,
	input wire logic o_ready_busy_flag,
	input wire logic o_global_req
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	// Long enough for the pin synchroniser to have settled
	sequence wp_held;
		(!i_wp_n && !o_quad_enable)[*4] ##0 o_protection_lock;
	endsequence
	chk_latch_set: assert property (i_write_enable |=> o_write_latch)
		else $error("latch not set");
	chk_lock_latch: assert property ($changed(o_protection_lock) |-> $past(o_write_latch))
		else $error("lock moved without latch");
	chk_wp_keep: assert property (wp_held |=> o_protection_lock)
		else $error("lock cleared under protect pin");
	chk_reset_en_latch: assert property ($changed(o_soft_reset_enable) |-> $past(o_write_latch))
		else $error("reset enable moved without latch");
	chk_lockdown_latch: assert property ($rose(o_lockdown_enable) |-> $past(o_write_latch))
		else $error("lockdown enable rose without latch");
	chk_freeze_hold: assert property (i_freeze_lockdown |=> !o_lockdown_enable [*8])
		else $error("lockdown enable after freeze");
	chk_glob_pulse: assert property (o_global_req |=> !o_global_req)
		else $error("global request too long");
	chk_quad_follow: assert property ($rose(i_nv_quad_enable) |-> ##[1:3] o_quad_enable)
		else $error("quad enable not followed");
	chk_wp_disable: assert property (o_wp_pause_disable == o_quad_enable)
		else $error("pin disable differs");
	chk_ready_copy: assert property (o_ready_busy_flag == $past(i_busy))
		else $error("ready flag wrong");
	chk_so_float: assert property (i_cs_n |-> !o_so_oe)
		else $error("output driven while deselected");
endmodule
bind fscw_status_config fscw_sc_chk u_chk (.*);

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic       i_clock, i_resetn, i_wp_n, i_quad, i_busy, i_we, i_frz, oe_seen;
	logic       sck, cs_n, si, so, so_oe, lock, latch, srst_en, lkd_en, quad, wpd, rdy, greq;
	logic [3:0] gfld, gfield;
	int         error_cnt = 0, tests_run = 0, gcnt = 0, cyc = 0;
	fscw_status_config DUT (.i_clock(i_clock), .i_resetn(i_resetn), .i_sck(sck),
		.i_cs_n(cs_n), .i_si(si), .i_wp_n(i_wp_n), .i_nv_quad_enable(i_quad),
		.i_busy(i_busy), .i_write_enable(i_we), .i_freeze_lockdown(i_frz), .o_so(so),
		.o_so_oe(so_oe), .o_protection_lock(lock), .o_write_latch(latch),
		.o_soft_reset_enable(srst_en), .o_lockdown_enable(lkd_en), .o_quad_enable(quad),
		.o_wp_pause_disable(wpd), .o_ready_busy_flag(rdy), .o_global_req(greq),
		.o_global_field(gfld));
	fscw_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));
	initial begin
		i_clock = 1'h0;
		forever #2 i_clock = ~i_clock;
	end
	always @(posedge i_clock) if (greq === 1'h1) begin
		gcnt++;
		gfield = gfld;
	end
	always @(posedge sck) if (so_oe === 1'h1) oe_seen = 1'h1;
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (error_cnt == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic pulse(input bit frz);
		@(posedge i_clock) if (frz) i_frz <= 1'h1; else i_we <= 1'h1;
		@(posedge i_clock) {i_frz, i_we} <= 2'h0;
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int n);
		host.frame({op, d, 16'h0000}, n);
	endtask
	task automatic rst();
		@(posedge i_clock) i_resetn <= 1'h0;
		repeat (4) @(posedge i_clock);
		i_resetn <= 1'h1;
		repeat (4) @(posedge i_clock);
	endtask
	task automatic t_lock();
		cmd(8'h01, 8'h80, 16);
		chk("lock_nolatch", 8'h00, 8'(lock));
		pulse(0);
		cmd(8'h01, 8'hD7, 24);
		chk("lock_set", 8'h01, 8'(lock));
		chk("latch", 8'h00, 8'(latch));
		chk("glob_cnt", 8'h01, gcnt[7:0]);
		chk("glob_fld", 8'h05, 8'(gfield));
	endtask
	task automatic t_wp();
		@(posedge i_clock) i_wp_n <= 1'h0;
		pulse(0);
		cmd(8'h01, 8'h00, 16);
		chk("lock_wp", 8'h01, 8'(lock));
		chk("latch_wp", 8'h00, 8'(latch));
		@(posedge i_clock) i_wp_n <= 1'h1;
		pulse(0);
		cmd(8'h01, 8'h00, 16);
		chk("lock_clr", 8'h00, 8'(lock));
		chk("glob_locked", 8'h01, gcnt[7:0]);
	endtask
	task automatic t_abort();
		pulse(0);
		cmd(8'h01, 8'h80, 12);
		chk("lock_short", 8'h00, 8'(lock));
		chk("latch_short", 8'h00, 8'(latch));
		pulse(0);
		cmd(8'h31, 8'h18, 20);
		chk("rst_en_unal", 8'h00, 8'(srst_en));
		chk("latch_unal", 8'h00, 8'(latch));
	endtask
	task automatic t_en();
		pulse(0);
		cmd(8'h31, 8'h18, 16);
		chk("en_set", 8'h03, {6'h00, srst_en, lkd_en});
		pulse(0);
		cmd(8'h31, 8'hE7, 16);
		chk("en_clr", 8'h00, {6'h00, srst_en, lkd_en});
		pulse(1);
		pulse(0);
		cmd(8'h31, 8'h08, 16);
		chk("en_frozen", 8'h00, {6'h00, srst_en, lkd_en});
	endtask
	task automatic t_cfg();
		@(posedge i_clock) i_quad <= 1'h1;
		rst();
		oe_seen = 1'h0;
		cmd(8'h3F, 8'h00, 24);
		chk("cfg_first", 8'h80, host.rd_q[15:8]);
		chk("cfg_repeat", 8'h80, host.rd_q[7:0]);
		chk("quad_en", 8'h01, 8'(quad));
		chk("oe_read", 8'h01, 8'(oe_seen));
		chk("pin_dis", 8'h01, 8'(wpd));
		oe_seen = 1'h0;
		@(posedge i_clock) i_busy <= 1'h1;
		cmd(8'h3F, 8'h00, 16);
		chk("oe_busy", 8'h00, 8'(oe_seen));
		chk("rdy", 8'h01, 8'(rdy));
	endtask
	initial begin
		{i_resetn, i_wp_n, i_quad, i_busy, i_we, i_frz} = 6'h10;
		rst();
		cmd(8'h00, 8'h00, 8);
		t_lock();
		t_wp();
		t_abort();
		t_en();
		t_cfg();
		wrap_up();
	end
endmodule
